// ==== rtl/raw_debounce.sv ====
`timescale 1ns/10ps
module raw_debounce
    import raw_pkg::*;
#(
    parameter int unsigned CYCLES = DEBOUNCE_CYC
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic raw_n,
    output logic      clean_n
);
    // ---------------------------------------------------------------
    // Stable-level filter
    // ---------------------------------------------------------------
    logic [23:0] cnt_r;
    logic [23:0] cnt_nxt;
    logic        clean_r;
    logic        clean_nxt;

    // A level is accepted only after it has held for the full settle time
    always_comb begin
        cnt_nxt   = cnt_r;
        clean_nxt = clean_r;
        if (raw_n == clean_r) begin
            cnt_nxt = 24'h000000;
        end else if (cnt_r >= 24'(CYCLES - 1)) begin
            cnt_nxt   = 24'h000000;
            clean_nxt = raw_n;
        end else begin
            cnt_nxt = cnt_r + 24'h000001;
        end
    end

    // Rests released (high) so a power-up glitch cannot fire a reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r   <= 24'h000000;
            clean_r <= 1'b1;
        end else begin
            cnt_r   <= cnt_nxt;
            clean_r <= clean_nxt;
        end
    end

    assign clean_n = clean_r;
endmodule

// ==== rtl/raw_top.sv ====
`timescale 1ns/10ps
module raw_top
    import raw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned DEB_CYCLES  = DEBOUNCE_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire raw_cfg_t           cfg,
    input  wire logic               rearm,
    input  wire logic               alarm_clear,
    input  wire logic               reset_button_n,
    input  wire logic               keyboard_lock_input_n,
    input  wire logic               kbd_data_in,
    input  wire logic               kbd_valid_in,
    input  wire logic               cfg_wr,
    input  wire logic [3:0]         cfg_addr,
    input  wire logic [CFG_W-1:0]   cfg_wdata,
    input  wire logic               cfg_lost,
    input  wire logic [CFG_W-1:0]   nv_rdata,
    output logic                    alarm_out,
    output raw_evt_t                evt,
    output logic                    kbd_data_out,
    output logic                    kbd_valid_out,
    output logic [CFG_W-1:0]        cfg_rdata,
    output logic                    nv_wr,
    output logic                    nv_rd,
    output logic [3:0]              nv_addr,
    output logic [CFG_W-1:0]        nv_wdata,
    output logic                    restore_busy
);
    // ---------------------------------------------------------------
    // Manual reset debounce
    // ---------------------------------------------------------------
    logic btn_clean_n;

    raw_debounce #(
        .CYCLES (DEB_CYCLES)
    ) u_btn (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .raw_n    (reset_button_n),
        .clean_n  (btn_clean_n)
    );

    // ---------------------------------------------------------------
    // Alarm countdown
    // ---------------------------------------------------------------
    raw_state_t  st_r;
    raw_state_t  st_nxt;
    logic [17:0] pre_r;
    logic [17:0] pre_nxt;
    logic [16:0] ms_r;
    logic [16:0] ms_nxt;
    logic        alarm_r;
    logic        alarm_nxt;
    logic        btn_prev_r;
    logic        btn_prev_nxt;
    logic [7:0]  rst_cnt_r;
    logic [7:0]  rst_cnt_nxt;
    logic        chck_n_r;
    logic        chck_n_nxt;
    logic        hrst_r;
    logic        hrst_nxt;
    logic [16:0] load_ms;
    logic        btn_press;

    // Interval select to milliseconds; zero means the alarm never arms
    always_comb begin
        case (cfg.interval_sel)
            SEL_30:  load_ms = 17'(INT_30_S * MS_PER_SEC);
            SEL_60:  load_ms = 17'(INT_60_S * MS_PER_SEC);
            SEL_90:  load_ms = 17'(INT_90_S * MS_PER_SEC);
            default: load_ms = 17'h00000;
        endcase
    end

    assign btn_press = btn_prev_r & ~btn_clean_n;

    // Millisecond prescaler keeps the second counts narrow
    always_comb begin
        st_nxt       = st_r;
        pre_nxt      = pre_r;
        ms_nxt       = ms_r;
        alarm_nxt    = alarm_r;
        btn_prev_nxt = btn_clean_n;
        rst_cnt_nxt  = rst_cnt_r;
        chck_n_nxt   = chck_n_r;
        hrst_nxt     = hrst_r;
        // Service clears the alarm; a new expiry in that cycle still wins
        if (alarm_clear) begin
            alarm_nxt = 1'b0;
        end
        case (st_r)
            RAW_IDLE: begin
                if (rearm && load_ms != 17'h00000) begin
                    st_nxt  = RAW_COUNT;
                    pre_nxt = 18'h00000;
                    ms_nxt  = load_ms;
                end
            end
            RAW_COUNT: begin
                if (rearm) begin
                    pre_nxt = 18'h00000;
                    ms_nxt  = load_ms;
                    if (load_ms == 17'h00000) begin
                        st_nxt = RAW_IDLE;
                    end
                end else if (pre_r >= 18'(TICK_CYCLES - 1)) begin
                    pre_nxt = 18'h00000;
                    if (ms_r <= 17'h00001) begin
                        st_nxt    = RAW_FIRED;
                        alarm_nxt = 1'b1;
                    end else begin
                        ms_nxt = ms_r - 17'h00001;
                    end
                end else begin
                    pre_nxt = pre_r + 18'h00001;
                end
            end
            RAW_FIRED: begin
                // Route acts once per expiry; re-arm starts a fresh interval except on the reset route, which goes to RAW_RST
                case (cfg.timeout_route_select)
                    RAW_ROUTE_CHCK:  chck_n_nxt = 1'b0;
                    RAW_ROUTE_RESET: begin
                        st_nxt      = RAW_RST;
                        rst_cnt_nxt = 8'(RESET_PULSE_CYC);
                    end
                    default:         chck_n_nxt = 1'b1;
                endcase
                if (cfg.timeout_route_select != RAW_ROUTE_RESET) begin
                    st_nxt = rearm ? RAW_COUNT : RAW_IDLE;
                    pre_nxt = 18'h00000;
                    ms_nxt  = load_ms;
                    if (rearm && load_ms == 17'h00000) begin
                        st_nxt = RAW_IDLE;
                    end
                end
            end
            RAW_RST: begin
                if (rst_cnt_r <= 8'h01) begin
                    st_nxt      = RAW_IDLE;
                    rst_cnt_nxt = 8'h00;
                end else begin
                    rst_cnt_nxt = rst_cnt_r - 8'h01;
                end
            end
            default: st_nxt = RAW_IDLE;
        endcase
        // Channel check holds until the alarm is serviced
        if (alarm_clear && !(st_r == RAW_COUNT && alarm_nxt)) begin
            chck_n_nxt = 1'b1;
        end
        // Watchdog and button share one reset pulse shape
        if (btn_press && st_r != RAW_RST) begin
            st_nxt      = RAW_RST;
            rst_cnt_nxt = 8'(RESET_PULSE_CYC);
        end
        hrst_nxt = (st_nxt == RAW_RST);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r       <= RAW_IDLE;
            pre_r      <= 18'h00000;
            ms_r       <= 17'h00000;
            alarm_r    <= 1'b0;
            btn_prev_r <= 1'b1;
            rst_cnt_r  <= 8'h00;
            chck_n_r   <= 1'b1;
            hrst_r     <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            pre_r      <= pre_nxt;
            ms_r       <= ms_nxt;
            alarm_r    <= alarm_nxt;
            btn_prev_r <= btn_prev_nxt;
            rst_cnt_r  <= rst_cnt_nxt;
            chck_n_r   <= chck_n_nxt;
            hrst_r     <= hrst_nxt;
        end
    end

    assign alarm_out      = alarm_r;
    // Channel check is held active low in its flop so the pin needs no inverter
    assign evt = '{
        irq_rtc:    alarm_r,
        io_chck_n:  chck_n_r,
        hard_reset: hrst_r
    };

    // ---------------------------------------------------------------
    // Keyboard lock
    // ---------------------------------------------------------------
    logic kbd_data_r;
    logic kbd_data_nxt;
    logic kbd_valid_r;
    logic kbd_valid_nxt;

    // Lock gates the strobe only, so no partial byte leaks through
    always_comb begin
        kbd_data_nxt  = kbd_data_in;
        kbd_valid_nxt = kbd_valid_in & keyboard_lock_input_n;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            kbd_data_r  <= 1'b0;
            kbd_valid_r <= 1'b0;
        end else begin
            kbd_data_r  <= kbd_data_nxt;
            kbd_valid_r <= kbd_valid_nxt;
        end
    end

    assign kbd_data_out  = kbd_data_r;
    assign kbd_valid_out = kbd_valid_r;

    // ---------------------------------------------------------------
    // Configuration memory with nonvolatile mirror
    // ---------------------------------------------------------------
    logic [CFG_W-1:0] cfg_mem [CFG_WORDS];
    logic [CFG_W-1:0] rdata_r;
    logic             nv_wr_r;
    logic             nv_wr_nxt;
    logic             nv_rd_r;
    logic             nv_rd_nxt;
    logic [3:0]       nv_addr_r;
    logic [3:0]       nv_addr_nxt;
    logic [CFG_W-1:0] nv_wdata_r;
    logic [CFG_W-1:0] nv_wdata_nxt;
    logic             busy_r;
    logic             busy_nxt;
    logic             cap_r;
    logic             cap_nxt;

    // Writes outside a loss or restore are mirrored; a loss walks all words back one per two cycles
    always_comb begin
        nv_wr_nxt    = 1'b0;
        nv_rd_nxt    = 1'b0;
        nv_addr_nxt  = nv_addr_r;
        nv_wdata_nxt = nv_wdata_r;
        busy_nxt     = busy_r;
        cap_nxt      = 1'b0;
        if (busy_r) begin
            if (cap_r) begin
                if (nv_addr_r == 4'hF) begin
                    busy_nxt = 1'b0;
                end else begin
                    nv_addr_nxt = nv_addr_r + 4'h1;
                    nv_rd_nxt   = 1'b1;
                end
            end else begin
                cap_nxt = 1'b1;
            end
        end else if (cfg_lost) begin
            busy_nxt    = 1'b1;
            nv_addr_nxt = 4'h0;
            nv_rd_nxt   = 1'b1;
        end else if (cfg_wr) begin
            nv_wr_nxt    = 1'b1;
            nv_addr_nxt  = cfg_addr;
            nv_wdata_nxt = cfg_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nv_wr_r    <= 1'b0;
            nv_rd_r    <= 1'b0;
            nv_addr_r  <= 4'h0;
            nv_wdata_r <= 8'h00;
            busy_r     <= 1'b0;
            cap_r      <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            nv_wr_r    <= nv_wr_nxt;
            nv_rd_r    <= nv_rd_nxt;
            nv_addr_r  <= nv_addr_nxt;
            nv_wdata_r <= nv_wdata_nxt;
            busy_r     <= busy_nxt;
            cap_r      <= cap_nxt;
            rdata_r    <= cfg_mem[cfg_addr];
        end
    end

    // Array kept out of reset so it maps onto plain RAM
    always_ff @(posedge core_clk) begin
        if (busy_r && cap_r) begin
            cfg_mem[nv_addr_r] <= nv_rdata;
        end else if (!busy_r && !cfg_lost && cfg_wr) begin
            cfg_mem[cfg_addr] <= cfg_wdata;
        end
    end

    assign cfg_rdata    = rdata_r;
    assign nv_wr        = nv_wr_r;
    assign nv_rd        = nv_rd_r;
    assign nv_addr      = nv_addr_r;
    assign nv_wdata     = nv_wdata_r;
    assign restore_busy = busy_r;
endmodule

// ==== shared/raw_pkg.sv ====
package raw_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 250000000;
    localparam int unsigned TICK_NS         = 1000000;     // Millisecond prescaler base: 1 ms in ns
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_PER_SEC      = 1000;
    localparam int unsigned INT_30_S        = 30;
    localparam int unsigned INT_60_S        = 60;
    localparam int unsigned INT_90_S        = 90;
    localparam int unsigned DEBOUNCE_NS     = 10000000;    // 10 ms settle time
    localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_PULSE_NS  = 1000;
    localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CFG_W           = 8;
    localparam int unsigned CFG_WORDS       = 16;

    // ---------------------------------------------------------------
    // Codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_DISABLE = 2'h0;
    localparam logic [1:0] SEL_30      = 2'h1;
    localparam logic [1:0] SEL_60      = 2'h2;
    localparam logic [1:0] SEL_90      = 2'h3;

    typedef enum logic [1:0] {
        RAW_ROUTE_OPEN  = 2'h0,
        RAW_ROUTE_CHCK  = 2'h1,
        RAW_ROUTE_RESET = 2'h2
    } raw_route_t;

    typedef enum logic [3:0] {
        RAW_IDLE  = 4'h1,
        RAW_COUNT = 4'h2,
        RAW_FIRED = 4'h4,
        RAW_RST   = 4'h8
    } raw_state_t;

    // Watchdog configuration carried as one bundle
    typedef struct packed {
        logic [1:0] interval_sel;
        raw_route_t timeout_route_select;
    } raw_cfg_t;

    // Outgoing system events
    typedef struct packed {
        logic irq_rtc;
        logic io_chck_n;
        logic hard_reset;
    } raw_evt_t;
endpackage

// ==== tb/raw_assertions.sv ====
`timescale 1ns/10ps
module raw_assertions
    import raw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned DEB_CYCLES  = DEBOUNCE_CYC
) (
    input wire logic             core_clk,
    input wire logic             sys_rst,
    input wire raw_cfg_t         cfg,
    input wire logic             alarm_clear,
    input wire logic             keyboard_lock_input_n,
    input wire logic             kbd_data_in,
    input wire logic             kbd_valid_in,
    input wire logic             cfg_wr,
    input wire logic [3:0]       cfg_addr,
    input wire logic [CFG_W-1:0] cfg_wdata,
    input wire logic             cfg_lost,
    input wire logic             alarm_out,
    input wire raw_evt_t         evt,
    input wire logic             kbd_data_out,
    input wire logic             kbd_valid_out,
    input wire logic             nv_wr,
    input wire logic [3:0]       nv_addr,
    input wire logic [CFG_W-1:0] nv_wdata,
    input wire logic             restore_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Length of the running hard reset pulse
    logic [8:0] hr_cnt_r;
    logic [8:0] hr_cnt_nxt;
    always_comb begin
        hr_cnt_nxt = evt.hard_reset ? hr_cnt_r + 9'h001 : 9'h000;
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            hr_cnt_r <= 9'h000;
        else
            hr_cnt_r <= hr_cnt_nxt;
    end

    property p_irq; alarm_out == evt.irq_rtc; endproperty
    a_irq: assert property (p_irq) else $error("irq differs from alarm");
    property p_chck;
        $rose(alarm_out) && cfg.timeout_route_select == RAW_ROUTE_CHCK |=> !evt.io_chck_n;
    endproperty
    a_chck: assert property (p_chck) else $error("channel check missing");
    property p_hrst;
        $rose(alarm_out) && cfg.timeout_route_select == RAW_ROUTE_RESET |=> evt.hard_reset;
    endproperty
    a_hrst: assert property (p_hrst) else $error("hard reset missing");
    property p_open;
        $rose(alarm_out) && cfg.timeout_route_select == RAW_ROUTE_OPEN |=> evt.io_chck_n [*3];
    endproperty
    a_open: assert property (p_open) else $error("open route acted");
    property p_hrw; $fell(evt.hard_reset) |-> hr_cnt_r == RESET_PULSE_CYC; endproperty
    a_hrw: assert property (p_hrw) else $error("hard reset width wrong");
    property p_hold; alarm_out && !alarm_clear |=> alarm_out; endproperty
    a_hold: assert property (p_hold) else $error("alarm dropped early");
    property p_clr; alarm_clear |=> !alarm_out && evt.io_chck_n; endproperty
    a_clr: assert property (p_clr) else $error("alarm not cleared");
    property p_lock; (!keyboard_lock_input_n) [*2] |-> !kbd_valid_out; endproperty
    a_lock: assert property (p_lock) else $error("key passed while locked");
    property p_kbd;
        kbd_valid_in && keyboard_lock_input_n ##1 keyboard_lock_input_n
            |-> kbd_valid_out && kbd_data_out == $past(kbd_data_in);
    endproperty
    a_kbd: assert property (p_kbd) else $error("key lost while unlocked");
    property p_nvw;
        cfg_wr && !cfg_lost && !restore_busy |=> nv_wr && nv_addr == $past(cfg_addr) && nv_wdata == $past(cfg_wdata);
    endproperty
    a_nvw: assert property (p_nvw) else $error("config not mirrored");
    property p_rsto; cfg_lost |-> ##[1:2] restore_busy ##[1:80] !restore_busy; endproperty
    a_rsto: assert property (p_rsto) else $error("restore did not run");
endmodule

// ==== tb/raw_partner.sv ====
`timescale 1ns/10ps
module raw_partner
    import raw_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire raw_evt_t   evt,
    input wire logic [7:0] svc_dly,
    input wire logic       nv_wr,
    input wire logic       nv_rd,
    input wire logic [3:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    output logic           alarm_clear,
    output logic [7:0]     nv_rdata
);
    logic [7:0] nv_mem [16];
    logic [7:0] wait_r;

    // Interrupt service answers after a delay the bench picks
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_clear <= 1'b0;
            wait_r <= 8'h00;
        end else begin
            alarm_clear <= 1'b0;
            if (evt.irq_rtc && !alarm_clear) begin
                wait_r <= wait_r + 8'h01;
                if (wait_r == svc_dly) begin
                    alarm_clear <= 1'b1;
                    wait_r <= 8'h00;
                end
            end
        end
    end

    // Storage; off-read data toggles so stale bytes never look valid
    initial nv_rdata = 8'h5A;
    always @(posedge core_clk) begin
        if (nv_wr)
            nv_mem[nv_addr] <= nv_wdata;
        nv_rdata <= nv_rd ? nv_mem[nv_addr] : ~nv_rdata;
    end
endmodule

// ==== tb/raw_tb.sv ====
`timescale 1ns/10ps
bind raw_top raw_assertions #(.TICK_CYCLES(TICK_CYCLES), .DEB_CYCLES(DEB_CYCLES)) u_chk (
    .core_clk, .sys_rst, .cfg, .alarm_clear, .keyboard_lock_input_n, .kbd_data_in,
    .kbd_valid_in, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_lost, .alarm_out, .evt,
    .kbd_data_out, .kbd_valid_out, .nv_wr, .nv_addr, .nv_wdata, .restore_busy);
module tb;
    import raw_pkg::*;
    localparam int unsigned TK = 1;
    logic       core_clk, sys_rst, rearm, alarm_clear, reset_button_n, keyboard_lock_input_n;
    logic       kbd_data_in, kbd_valid_in, cfg_wr, cfg_lost, nv_wr, nv_rd, alarm_out;
    logic       kbd_data_out, kbd_valid_out, restore_busy, l1, l2, v1, d1;
    logic [3:0] cfg_addr, nv_addr;
    logic [7:0] cfg_wdata, nv_rdata, cfg_rdata, nv_wdata, svc_dly, b;
    logic [7:0] mem [16];
    raw_cfg_t   cfg;
    raw_evt_t   evt;
    int         n_fail, checks_done, hr_n, hb, n, rd_n;

    raw_top #(.TICK_CYCLES(TK), .DEB_CYCLES(4)) DUT (.core_clk, .sys_rst, .cfg, .rearm,
        .alarm_clear, .reset_button_n, .keyboard_lock_input_n, .kbd_data_in, .kbd_valid_in,
        .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_lost, .nv_rdata, .alarm_out, .evt, .kbd_data_out,
        .kbd_valid_out, .cfg_rdata, .nv_wr, .nv_rd, .nv_addr, .nv_wdata, .restore_busy);
    raw_partner u_far (.core_clk, .sys_rst, .evt, .svc_dly, .nv_wr, .nv_rd, .nv_addr,
        .nv_wdata, .alarm_clear, .nv_rdata);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bound(input int lim);
        if (n >= lim) begin
            n_fail++;
            $display("ERROR t=%0t wait limit got=%h exp=%h", $time, n, lim - 1);
            summarize();
        end
    endtask
    task automatic pulse_rearm();
        @(posedge core_clk) rearm <= 1'b1;
        @(posedge core_clk) rearm <= 1'b0;
    endtask
    task automatic rd_all();
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk) cfg_addr <= 4'(i);
            @(posedge core_clk) #1 chk(cfg_rdata, mem[i]);
        end
    endtask
    // Cycles from re-arm to alarm for an interval code
    function automatic int exp_cyc(input logic [1:0] sel);
        case (sel)
            SEL_30:  return TK * MS_PER_SEC * INT_30_S;
            SEL_60:  return TK * MS_PER_SEC * INT_60_S;
            default: return TK * MS_PER_SEC * INT_90_S;
        endcase
    endfunction

    // Clock and hard reset cycle tally
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (evt.hard_reset === 1'b1) hr_n++;
    always @(posedge core_clk) if (nv_rd === 1'b1) rd_n++;

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {sys_rst, reset_button_n, keyboard_lock_input_n} = 3'h7;
        {rearm, kbd_data_in, kbd_valid_in, cfg_wr, cfg_lost} = 5'h00;
        {cfg_addr, cfg_wdata, svc_dly, cfg} = '0;
        {n_fail, checks_done, hr_n, rd_n, l1, l2, v1, d1} = '0;
        b = 8'($urandom(32'h6208));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Random keys with the lock toggling now and then
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            kbd_data_in <= 1'($urandom);
            kbd_valid_in <= 1'($urandom);
            if ($urandom_range(7) == 0) keyboard_lock_input_n <= ~keyboard_lock_input_n;
            #1;
            if (i > 1 && l1 == l2) chk(kbd_valid_out, v1 & l1);
            if (i > 1) chk(kbd_data_out, d1);
            {l2, l1, v1, d1} = {l1, keyboard_lock_input_n, kbd_valid_in, kbd_data_in};
        end
        // Back-to-back config writes, readback, then loss and restore
        for (int i = 0; i < 16; i++) begin
            b = 8'($urandom);
            mem[i] = b;
            @(posedge core_clk) {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, 4'(i), b};
        end
        @(posedge core_clk) cfg_wr <= 1'b0;
        rd_all();
        @(posedge core_clk) cfg_lost <= 1'b1;
        @(posedge core_clk) cfg_lost <= 1'b0;
        repeat (3) @(posedge core_clk);
        for (n = 0; restore_busy !== 1'b0 && n < 200; n++) @(posedge core_clk);
        bound(200);
        chk(rd_n, CFG_WORDS);
        rd_all();
        // Button: a bounce is ignored, a held press gives one reset pulse
        hb = hr_n;
        @(posedge core_clk) reset_button_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_button_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk(hr_n - hb, 0);
        @(posedge core_clk) reset_button_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        reset_button_n <= 1'b1;
        repeat (300) @(posedge core_clk);
        chk(hr_n - hb, RESET_PULSE_CYC);
        // Disabled interval never fires
        @(posedge core_clk) cfg <= '{SEL_DISABLE, RAW_ROUTE_OPEN};
        pulse_rearm();
        repeat (200) @(posedge core_clk);
        #1 chk(alarm_out, 0);
        // Each route: re-arm mid-count, then time the alarm from the last re-arm
        for (int r = 0; r < 3; r++) begin
            @(posedge core_clk) cfg <= '{SEL_30, raw_route_t'(r)};
            svc_dly <= 8'($urandom_range(20, 1));
            pulse_rearm();
            repeat (100) @(posedge core_clk);
            pulse_rearm();
            hb = hr_n;
            for (n = 0; alarm_out !== 1'b1 && n < exp_cyc(SEL_30) + 10; n++) @(posedge core_clk) #1;
            bound(exp_cyc(SEL_30) + 10);
            chk(n >= exp_cyc(SEL_30) && n <= exp_cyc(SEL_30) + 1, 1);
            @(posedge core_clk) #1 chk(evt.irq_rtc, 1);
            chk(evt.io_chck_n, r != 1);
            for (n = 0; alarm_out !== 1'b0 && n < 100; n++) @(posedge core_clk) #1;
            bound(100);
            chk(evt.io_chck_n, 1);
            repeat (300) @(posedge core_clk);
            chk(hr_n - hb, r == 2 ? RESET_PULSE_CYC : 0);
        end
        summarize();
    end
endmodule
